// ---- design/sgu_pkg.sv ----
// Constants, types and register map of the sector guard host controller.
// Assumes a 125 MHz system clock and one serial flash on the far side of the link.
//
// Behaviour
// - Host should write zero to the chip-erase lockout location 008h when done.
// - Host should also write zero to location guard_finalize_byte when done.
// - Guard read sends opcode then a three-byte location, MSB first.
// - Host may end a read by raising chip enable; device stops driving.
// - Guard erase needs five correct consecutive instructions, else ignored.
// - Guard program needs five correct consecutive instructions, else discarded.
// - Guard erase takes at most 15 ms; host waits that long.
// - Guard program takes typically 2 ms, at most 5 ms; host waits.
// - Only one sector open at once; host must close before opening another.
// - Host sends write enable 06h before the open command.
package sgu_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_MHZ       = 125;
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned T_CEH_NS      = 25;
   localparam int unsigned CEH_CYC       = (T_CEH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned T_ERASE_US    = 15000;
   localparam int unsigned ERASE_CYC     = T_ERASE_US * CLK_MHZ;
   localparam int unsigned T_PROG_US     = 5000;
   localparam int unsigned PROG_CYC      = T_PROG_US * CLK_MHZ;
   localparam int unsigned HALF_DIV_DEF  = 4;

   // ---------------------------------------------------------------
   // Controller registers (byte addresses on the bus)
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_LEN    = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_DATA   = 8'h10;
   localparam logic [7:0] REG_BPTR   = 8'h14;
   localparam int unsigned ST_BUSY   = 0;
   localparam int unsigned ST_ERR    = 1;
   localparam int unsigned ST_OPEN   = 2;
   localparam int unsigned ST_SECT   = 4;
   localparam logic [8:0]  LEN_RST   = 9'h001;
   localparam logic [8:0]  LEN_MAX   = 9'h100;

   // ---------------------------------------------------------------
   // Device guard map and fixed opcodes
   // ---------------------------------------------------------------
   localparam logic [23:0] GUARD_LO_LOC   = 24'h000000;
   localparam logic [23:0] GUARD_HI_LOC   = 24'h000001;
   localparam logic [23:0] LOCKOUT_LOC    = 24'h000008;
   localparam logic [23:0] FINALIZE_LOC   = 24'h000009;
   localparam int unsigned SECT_LSB       = 12;
   localparam logic [7:0]  OP_WREN        = 8'h06;
   localparam logic [7:0]  OP_OPEN_SECT   = 8'h26;
   localparam logic [7:0]  OP_CLOSE_SECT  = 8'h24;
   localparam logic [7:0]  OP_GREAD_DEF   = 8'h4b;
   localparam logic [39:0] ERASE_SEQ_DEF  = 40'h06_a1_06_a2_a3;
   localparam logic [39:0] PROG_SEQ_DEF   = 40'h06_b1_06_b2_b3;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      SGU_NONE, SGU_READ, SGU_ERASE, SGU_PROG, SGU_OPEN, SGU_CLOSE
   } sgu_cmd_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } sgu_wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } sgu_wb_rsp_t;

   typedef struct packed {
      logic sck;
      logic ce_n;
      logic host_data_in_line;
   } sgu_link_t;

endpackage : sgu_pkg

// ---- design/sgu_buf.sv ----
// Byte buffer for guard data moving between the bus and the serial link.
// Assumes one writer per cycle; read data appear one clock after the address.
`timescale 1ns/1ps
module sgu_buf #(
   parameter int unsigned AW = 8,
   parameter int unsigned DW = 8
) (
   // Clock, reset, enable
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          en_i,
   // Write port
   input  wire logic          we_i,
   input  wire logic [AW-1:0] wa_i,
   input  wire logic [DW-1:0] wd_i,
   // Read port
   input  wire logic [AW-1:0] ra_i,
   output logic      [DW-1:0] rd_o
);

   logic [DW-1:0] mem_ff [2**AW];

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   // Array has no reset, so it maps onto plain RAM
   always_ff @(posedge clk_i) begin
      if (en_i && we_i) begin
         mem_ff[wa_i] <= wd_i;
      end
   end

   // Registered read port
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_o <= '0;
      end else if (en_i) begin
         rd_o <= mem_ff[ra_i];
      end
   end

endmodule : sgu_buf

// ---- design/sgu_host.sv ----
// Serial host that reads, erases and programs the guard bits of a flash
// and opens or closes one sector, under orders from a Wishbone slave port.
// Assumes the flash answers on its data output in mode 0 timing.
`timescale 1ns/1ps
module sgu_host #(
   parameter int unsigned HALF_DIV   = sgu_pkg::HALF_DIV_DEF,
   parameter int unsigned ERASE_WAIT = sgu_pkg::ERASE_CYC,
   parameter int unsigned PROG_WAIT  = sgu_pkg::PROG_CYC,
   parameter logic [7:0]  GREAD_OP   = sgu_pkg::OP_GREAD_DEF,
   parameter logic [39:0] ERASE_SEQ  = sgu_pkg::ERASE_SEQ_DEF,
   parameter logic [39:0] PROG_SEQ   = sgu_pkg::PROG_SEQ_DEF
) (
   // Clock, reset, enable
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 en_i,
   // Wishbone slave
   input  wire sgu_pkg::sgu_wb_req_t wb_i,
   output sgu_pkg::sgu_wb_rsp_t      wb_o,
   // Serial link
   output sgu_pkg::sgu_link_t        link_o,
   input  wire logic                 dev_data_out_i
);
   import sgu_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_FRAME, S_GAP, S_WAIT} sgu_state_t;

   typedef struct packed {
      logic        pend;
      logic        ack;
      logic [31:0] dat;
      sgu_cmd_t    cmd;
      logic [23:0] addr;
      logic [8:0]  len;
      logic        err;
      logic        open;
      logic [11:0] open_sect;
      logic [7:0]  bptr;
      sgu_state_t  st;
      logic [2:0]  step;
      logic [9:0]  bidx;
      logic [2:0]  bitc;
      logic [7:0]  div;
      logic        sck;
      logic        ce_n;
      logic        mosi;
      logic [7:0]  tx;
      logic [7:0]  rx;
      logic [31:0] tmr;
      logic        so_s1;
      logic        so_s2;
   } sgu_state_reg_t;

   sgu_state_reg_t s_ff;
   sgu_state_reg_t nxt_s;
   logic           mem_we;
   logic [7:0]     mem_wa;
   logic [7:0]     mem_wd;
   logic [7:0]     mem_ra;
   logic [7:0]     mem_rd;

   // ---------------------------------------------------------------
   // Step decoding
   // ---------------------------------------------------------------
   // Opcode of a given step; the five-step sequences come from parameters
   function automatic logic [7:0] step_op(input sgu_cmd_t c, input logic [2:0] k);
      int i;
      i = 4 - int'(k);
      unique case (c)
         SGU_READ:  step_op = GREAD_OP;
         SGU_ERASE: step_op = ERASE_SEQ[i*8 +: 8];
         SGU_PROG:  step_op = PROG_SEQ[i*8 +: 8];
         SGU_OPEN:  step_op = (k == 3'd0) ? OP_WREN : OP_OPEN_SECT;
         SGU_CLOSE: step_op = OP_CLOSE_SECT;
         default:   step_op = 8'h00;
      endcase
   endfunction : step_op

   // Last step of each command
   function automatic logic last_step(input sgu_cmd_t c, input logic [2:0] k);
      unique case (c)
         SGU_ERASE, SGU_PROG: last_step = (k == 3'd4);
         SGU_OPEN:            last_step = (k == 3'd1);
         default:             last_step = (k == 3'd0);
      endcase
   endfunction : last_step

   // Byte b of the frame
   function automatic logic [7:0] frame_byte(input logic [9:0] b, input logic [23:0] a,
                                             input logic [7:0] d);
      unique case (b)
         10'd1:   frame_byte = a[23:16];
         10'd2:   frame_byte = a[15:8];
         10'd3:   frame_byte = a[7:0];
         default: frame_byte = d;
      endcase
   endfunction : frame_byte

   // Byte-lane merge for a bus write
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = o;
      for (int j = 0; j < 4; j++) begin
         if (sel[j]) begin
            r[j*8 +: 8] = d[j*8 +: 8];
         end
      end
      merge = r;
   endfunction : merge

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   logic        lst;
   logic        has_addr;
   logic [9:0]  tot;
   logic [7:0]  rx_byte;
   logic [9:0]  nb;
   logic [31:0] adr_rd;
   logic [31:0] tmp;
   sgu_cmd_t    new_cmd;
   logic        cmd_ok;

   always_comb begin
      nxt_s    = s_ff;
      lst      = last_step(s_ff.cmd, s_ff.step);
      has_addr = lst && (s_ff.cmd != SGU_CLOSE);
      tot      = 10'd1 + (has_addr ? 10'd3 : 10'd0)
               + ((lst && (s_ff.cmd == SGU_READ || s_ff.cmd == SGU_PROG)) ? {1'b0, s_ff.len}
                                                                           : 10'd0);
      rx_byte  = {s_ff.rx[6:0], s_ff.so_s2};
      nb       = s_ff.bidx + 10'd1;
      mem_we   = 1'b0;
      mem_wa   = s_ff.bptr;
      mem_wd   = wb_i.dat[7:0];
      mem_ra   = (s_ff.st == S_IDLE) ? s_ff.bptr : 8'(nb - 10'd4);
      adr_rd   = 32'h0000_0000;
      tmp      = 32'h0000_0000;
      new_cmd  = sgu_cmd_t'(wb_i.dat[2:0]);
      cmd_ok   = 1'b0;

      // Data line from the device passes two flops before use
      nxt_s.so_s1 = dev_data_out_i;
      nxt_s.so_s2 = s_ff.so_s1;

      // Bus: take request, answer one cycle later from registers
      nxt_s.ack = 1'b0;
      if (wb_i.cyc && wb_i.stb && !s_ff.pend && !s_ff.ack) begin
         nxt_s.pend = 1'b1;
      end
      if (s_ff.pend) begin
         nxt_s.pend = 1'b0;
         nxt_s.ack  = 1'b1;
         unique case (wb_i.adr)
            REG_CTRL:   adr_rd = {29'h0, s_ff.cmd};
            REG_ADDR:   adr_rd = {8'h00, s_ff.addr};
            REG_LEN:    adr_rd = {23'h0, s_ff.len};
            REG_STATUS: adr_rd = {16'h0000, s_ff.open_sect, 1'b0, s_ff.open, s_ff.err,
                                  s_ff.st != S_IDLE};
            REG_DATA:   adr_rd = {24'h0, mem_rd};
            REG_BPTR:   adr_rd = {24'h0, s_ff.bptr};
            default:    adr_rd = 32'h0000_0000;
         endcase
         nxt_s.dat = wb_i.we ? 32'h0000_0000 : adr_rd;
         // Writes land only while idle, so a running command never sees them change
         if (wb_i.we && s_ff.st == S_IDLE) begin
            unique case (wb_i.adr)
               REG_ADDR: begin
                  tmp = merge({8'h00, s_ff.addr}, wb_i.dat, wb_i.sel);
                  nxt_s.addr = tmp[23:0];
               end
               REG_LEN: begin
                  tmp = merge({23'h0, s_ff.len}, wb_i.dat, wb_i.sel);
                  nxt_s.len = tmp[8:0];
               end
               REG_DATA: begin
                  if (wb_i.sel[0]) begin
                     mem_we     = 1'b1;
                     nxt_s.bptr = s_ff.bptr + 8'd1;
                  end
               end
               REG_BPTR: begin
                  if (wb_i.sel[0]) begin
                     nxt_s.bptr = wb_i.dat[7:0];
                  end
               end
               REG_CTRL: begin
                  if (wb_i.sel[0]) begin
                     unique case (new_cmd)
                        SGU_READ, SGU_PROG:
                           cmd_ok = (s_ff.len != 9'h000) && (s_ff.len <= LEN_MAX);
                        SGU_ERASE, SGU_CLOSE:
                           cmd_ok = 1'b1;
                        SGU_OPEN:
                           cmd_ok = !s_ff.open;
                        default:
                           cmd_ok = 1'b0;
                     endcase
                     nxt_s.err = !cmd_ok;
                     if (cmd_ok) begin
                        nxt_s.cmd   = new_cmd;
                        nxt_s.step  = 3'd0;
                        nxt_s.bptr  = 8'h00;
                        nxt_s.st    = S_FRAME;
                        nxt_s.bidx  = 10'd0;
                        nxt_s.bitc  = 3'd0;
                        nxt_s.div   = 8'h00;
                        nxt_s.ce_n  = 1'b0;
                        nxt_s.tx    = step_op(new_cmd, 3'd0);
                        nxt_s.mosi  = nxt_s.tx[7];
                     end
                  end
               end
               default: ;
            endcase
         end else if (!wb_i.we && wb_i.adr == REG_DATA && s_ff.st == S_IDLE) begin
            nxt_s.bptr = s_ff.bptr + 8'd1;
         end
      end

      // Serial engine
      unique case (s_ff.st)
         S_IDLE: ;
         S_FRAME: begin
            if (s_ff.div != 8'(HALF_DIV - 1)) begin
               nxt_s.div = s_ff.div + 8'd1;
            end else if (!s_ff.sck) begin
               nxt_s.div = 8'h00;
               nxt_s.sck = 1'b1;
            end else begin
               // Falling edge: sample, then present the next bit
               nxt_s.div  = 8'h00;
               nxt_s.sck  = 1'b0;
               nxt_s.rx   = rx_byte;
               nxt_s.bitc = s_ff.bitc + 3'd1;
               nxt_s.tx   = {s_ff.tx[6:0], 1'b0};
               if (s_ff.bitc == 3'd7) begin
                  if (s_ff.cmd == SGU_READ && s_ff.bidx >= 10'd4) begin
                     mem_we = 1'b1;
                     mem_wa = 8'(s_ff.bidx - 10'd4);
                     mem_wd = rx_byte;
                  end
                  if (nb == tot) begin
                     // Raise chip enable right after the last clock; the byte
                     // count keeps the open-sector frame at exactly 8 plus 24 clocks
                     nxt_s.ce_n = 1'b1;
                     nxt_s.st   = S_GAP;
                     nxt_s.tmr  = 32'(CEH_CYC);
                  end else begin
                     nxt_s.bidx = nb;
                     nxt_s.tx   = frame_byte(nb, s_ff.addr,
                                  (s_ff.cmd == SGU_PROG) ? mem_rd : 8'h00);
                  end
               end
               nxt_s.mosi = nxt_s.tx[7];
            end
         end
         S_GAP: begin
            if (s_ff.tmr > 32'd1) begin
               nxt_s.tmr = s_ff.tmr - 32'd1;
            end else if (!lst) begin
               // Next instruction of the sequence in its own frame
               nxt_s.step = s_ff.step + 3'd1;
               nxt_s.st   = S_FRAME;
               nxt_s.bidx = 10'd0;
               nxt_s.bitc = 3'd0;
               nxt_s.div  = 8'h00;
               nxt_s.ce_n = 1'b0;
               nxt_s.tx   = step_op(s_ff.cmd, s_ff.step + 3'd1);
               nxt_s.mosi = nxt_s.tx[7];
            end else begin
               unique case (s_ff.cmd)
                  SGU_ERASE: begin
                     nxt_s.st  = S_WAIT;
                     nxt_s.tmr = 32'(ERASE_WAIT);
                  end
                  SGU_PROG: begin
                     nxt_s.st  = S_WAIT;
                     nxt_s.tmr = 32'(PROG_WAIT);
                  end
                  SGU_OPEN: begin
                     nxt_s.open      = 1'b1;
                     nxt_s.open_sect = s_ff.addr[23:SECT_LSB];
                     nxt_s.st        = S_IDLE;
                  end
                  SGU_CLOSE: begin
                     nxt_s.open = 1'b0;
                     nxt_s.st   = S_IDLE;
                  end
                  default: nxt_s.st = S_IDLE;
               endcase
            end
         end
         S_WAIT: begin
            // No status polling: the worst-case time alone ends the wait
            if (s_ff.tmr > 32'd1) begin
               nxt_s.tmr = s_ff.tmr - 32'd1;
            end else begin
               nxt_s.st = S_IDLE;
            end
         end
      endcase
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_ff      <= '0;
         s_ff.cmd  <= SGU_NONE;
         s_ff.st   <= S_IDLE;
         s_ff.len  <= LEN_RST;
         s_ff.ce_n <= 1'b1;
      end else if (en_i) begin
         s_ff <= nxt_s;
      end
   end

   // ---------------------------------------------------------------
   // Buffer and outputs
   // ---------------------------------------------------------------
   sgu_buf #(
      .AW (8),
      .DW (8)
   ) u_buf (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .en_i  (en_i),
      .we_i  (mem_we),
      .wa_i  (mem_wa),
      .wd_i  (mem_wd),
      .ra_i  (mem_ra),
      .rd_o  (mem_rd)
   );

   // All outputs straight from flops
   assign wb_o.ack                 = s_ff.ack;
   assign wb_o.dat                 = s_ff.dat;
   assign link_o.sck               = s_ff.sck;
   assign link_o.ce_n              = s_ff.ce_n;
   assign link_o.host_data_in_line = s_ff.mosi;

endmodule : sgu_host

// ---- test/sgu_host_chk.sv ----
// Checker on the guard host ports: bus answer and serial framing.
// Assumes en_i stays high while it watches.
`timescale 1ns/1ps
module sgu_host_chk
#(
   parameter int unsigned HALF_DIV = sgu_pkg::HALF_DIV_DEF
) (
   // Watched ports
   input wire logic                 clk_i,
   input wire logic                 rst_i,
   input wire logic                 en_i,
   input wire sgu_pkg::sgu_wb_req_t wb_i,
   input wire sgu_pkg::sgu_wb_rsp_t wb_o,
   input wire sgu_pkg::sgu_link_t   link_o,
   input wire logic                 dev_data_out_i
);
   import sgu_pkg::*;
   // ----
   // Helpers
   // ----
   logic [3:0]  hcnt_ff;
   logic [11:0] nrise_ff;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Cycles since the link clock moved, and its rises in this frame
   always_ff @(posedge clk_i) begin
      hcnt_ff  <= link_o.ce_n ? 4'h0 : ($changed(link_o.sck) ? 4'h1 : hcnt_ff + 4'h1);
      nrise_ff <= link_o.ce_n ? 12'h0 : nrise_ff + {11'h0, $rose(link_o.sck)};
   end
   AST_ACK_LAT: assert property ($rose(wb_i.cyc && wb_i.stb)
      |-> !wb_o.ack ##1 !wb_o.ack ##1 wb_o.ack) else $error("ack latency");
   AST_ACK_ONE: assert property (wb_o.ack |=> !wb_o.ack) else $error("ack too long");
   AST_WR_DAT: assert property ($rose(wb_i.cyc && wb_i.stb) && wb_i.we
      |-> ##2 wb_o.dat == 32'h0) else $error("write data not zero");
   AST_SCK_IDLE: assert property (link_o.ce_n |-> !link_o.sck) else $error("clock moved");
   AST_SCK_HALF: assert property ($changed(link_o.sck) && !link_o.ce_n
      |-> hcnt_ff == 4'(HALF_DIV)) else $error("half period");
   AST_CE_GAP: assert property ($rose(link_o.ce_n) |-> link_o.ce_n [*4])
      else $error("deselect gap");
   AST_BYTES: assert property ($rose(link_o.ce_n) |-> nrise_ff[2:0] == 3'h0)
      else $error("partial byte");
   AST_DATA_FALL: assert property (!link_o.ce_n && !$past(link_o.ce_n)
      && $changed(link_o.host_data_in_line) |-> $fell(link_o.sck)) else $error("data moved");
endmodule : sgu_host_chk
bind sgu_host sgu_host_chk #(.HALF_DIV(HALF_DIV)) chk_u (.clk_i(clk_i), .rst_i(rst_i),
   .en_i(en_i), .wb_i(wb_i), .wb_o(wb_o), .link_o(link_o), .dev_data_out_i(dev_data_out_i));

// ---- test/sgu_dev_model.sv ----
// Behavioural flash holding the guard bytes and the open-sector state.
// Assumes mode 0 framing; block-protect bits are not modelled.
`timescale 1ns/1ps
module sgu_dev_model
#(
   parameter logic [7:0]  GREAD_OP  = sgu_pkg::OP_GREAD_DEF,
   parameter logic [39:0] ERASE_SEQ = sgu_pkg::ERASE_SEQ_DEF,
   parameter logic [39:0] PROG_SEQ  = sgu_pkg::PROG_SEQ_DEF
) (
   // Link
   input  wire sgu_pkg::sgu_link_t link_i,
   output logic                    dout_o
);
   import sgu_pkg::*;
   logic [7:0]  mem [16];
   logic [7:0]  fr [260];
   int          nb = 0;
   int          est = 0;
   int          pst = 0;
   logic        write_enable_latch = 1'b0;
   logic        open_ff = 1'b0;
   logic [11:0] sect = 12'h0;
   // Arbitrary old content, so an erase shows
   initial begin
      foreach (mem[i]) mem[i] = 8'h5a;
      dout_o = 1'b0;
   end
   always @(negedge link_i.ce_n) nb = 0;
   // Bits are taken on the rising clock, MSB first
   always @(posedge link_i.sck) begin
      if (!link_i.ce_n) begin
         fr[nb/8][7-nb%8] = link_i.host_data_in_line;
         nb++;
      end
   end
   // Guard bytes leave on the falling clock, location stepping per byte
   always @(negedge link_i.sck) begin
      if (!link_i.ce_n && fr[0] == GREAD_OP && nb >= 32) begin
         dout_o = mem[4'(fr[3] + 8'((nb - 32) / 8))][7 - (nb - 32) % 8];
      end
   end
   // Deselect: output left drifting, the finished frame acts
   always @(posedge link_i.ce_n) begin
      dout_o = ~dout_o;
      if (nb == 8 && fr[0] == OP_WREN) write_enable_latch = 1'b1;
      if (nb == 8 && fr[0] == OP_CLOSE_SECT) open_ff = 1'b0;
      // Block protection is ignored; only the one opened sector is recorded
      if (nb == 32 && fr[0] == OP_OPEN_SECT && write_enable_latch && !open_ff) begin
         open_ff = 1'b1;
         sect = {fr[1], fr[2][7:4]};
      end
      est = (nb == (est == 4 ? 32 : 8) && fr[0] == ERASE_SEQ[39-8*est -: 8]) ? est + 1 : 0;
      pst = ((pst == 4 ? (nb >= 40 && nb <= 2080 && nb % 8 == 0) : nb == 8)
            && fr[0] == PROG_SEQ[39-8*pst -: 8]) ? pst + 1 : 0;
      if (est == 5) begin
         foreach (mem[i]) mem[i] = 8'hff;
         est = 0;
      end
      if (pst == 5) begin
         for (int i = 0; i < (nb - 32) / 8; i++) mem[4'(fr[3] + 8'(i))] &= fr[4 + i];
         pst = 0;
      end
   end
endmodule : sgu_dev_model

// ---- test/testbench.sv ----
// Self-checking bench for the guard host, one task a scenario.
// Assumes the flash model and the bound checker are compiled before it.
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench;
   import sgu_pkg::*;
   // ----
   // Design and model
   // ----
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        dout;
   sgu_wb_req_t req = '0;
   sgu_wb_rsp_t rsp;
   sgu_link_t   link;
   logic [31:0] q;
   int          mismatches = 0;
   int          cmp_count = 0;
   always #4 clk_i = ~clk_i;
   // Short waits keep erase and program brief
   sgu_host #(.ERASE_WAIT(50), .PROG_WAIT(50)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
      .en_i(1'b1), .wb_i(req), .wb_o(rsp), .link_o(link), .dev_data_out_i(dout));
   sgu_dev_model dev_u (.link_i(link), .dout_o(dout));
   // One classic cycle; q holds what the ack edge carried
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk_i);
      req <= '{1'b1, 1'b1, w, a, 4'hf, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (rsp.ack !== 1'b1 && n < 20);
      q = rsp.dat;
      req <= '0;
      `CHK("ack", 1'b1, rsp.ack)
   endtask : wb
   // Order a command, then poll until idle; q ends as status
   task automatic run(input logic [2:0] c, input logic [23:0] a, input logic [8:0] l);
      int n = 0;
      wb(1'b1, REG_ADDR, {8'h00, a});
      wb(1'b1, REG_LEN, {23'h0, l});
      wb(1'b1, REG_CTRL, {29'h0, c});
      do begin
         wb(1'b0, REG_STATUS, 32'h0);
         n++;
      end while (q[ST_BUSY] !== 1'b0 && n < 8000);
      `CHK("idle", 1'b0, q[ST_BUSY])
   endtask : run
   task automatic t_regs();
      wb(1'b0, REG_LEN, 32'h0);
      `CHK("len", 32'h1, q)
      wb(1'b0, REG_STATUS, 32'h0);
      `CHK("status", 32'h0, q)
      wb(1'b1, REG_ADDR, 32'h00abcdef);
      wb(1'b0, REG_ADDR, 32'h0);
      `CHK("addr", 32'h00abcdef, q)
      wb(1'b0, 8'h20, 32'h0);
      `CHK("unmapped", 32'h0, q)
   endtask : t_regs
   // Bad codes and lengths are refused; the full length is taken
   task automatic t_bad();
      logic [2:0] cs [5] = '{3'h0, 3'h6, 3'h7, 3'h1, 3'h3};
      logic [8:0] ls [5] = '{9'h1, 9'h1, 9'h1, 9'h0, 9'h101};
      for (int i = 0; i < 5; i++) begin
         run(cs[i], 24'h0, ls[i]);
         `CHK("err", 1'b1, q[ST_ERR])
      end
      run(SGU_READ, 24'h0, 9'h100);
      `CHK("max len", 1'b0, q[ST_ERR])
   endtask : t_bad
   task automatic t_guard();
      logic [7:0] ex [3] = '{8'hfe, 8'h7f, 8'hff};
      run(SGU_ERASE, 24'h0, 9'h1);
      `CHK("erased", 8'hff, dev_u.mem[1])
      wb(1'b1, REG_BPTR, 32'h0);
      wb(1'b1, REG_DATA, 32'hfe);
      wb(1'b1, REG_DATA, 32'h7f);
      run(SGU_PROG, 24'h0, 9'h2);
      `CHK("lo", 8'hfe, dev_u.mem[0])
      `CHK("hi", 8'h7f, dev_u.mem[1])
      run(SGU_READ, GUARD_LO_LOC, 9'h3);
      for (int i = 0; i < 3; i++) begin
         wb(1'b0, REG_DATA, 32'h0);
         `CHK("read", ex[i], q[7:0])
      end
      wb(1'b1, REG_BPTR, 32'h0);
      wb(1'b1, REG_DATA, 32'h0);
      wb(1'b1, REG_DATA, 32'h0);
      run(SGU_PROG, LOCKOUT_LOC, 9'h2);
      `CHK("lockout", 8'h00, dev_u.mem[8])
      `CHK("final", 8'h00, dev_u.mem[9])
   endtask : t_guard
   // A second open is refused while one sector stands open
   task automatic t_open();
      run(SGU_OPEN, 24'h003abc, 9'h1);
      `CHK("open", 1'b1, dev_u.open_ff)
      `CHK("sect", 12'h003, dev_u.sect)
      `CHK("st sect", 12'h003, q[ST_SECT +: 12])
      `CHK("st open", 1'b1, q[ST_OPEN])
      run(SGU_OPEN, 24'h005000, 9'h1);
      `CHK("refuse", 1'b1, q[ST_ERR])
      `CHK("kept", 12'h003, dev_u.sect)
      run(SGU_CLOSE, 24'h0, 9'h1);
      `CHK("close", 1'b0, dev_u.open_ff)
      `CHK("st close", 1'b0, q[ST_OPEN])
   endtask : t_open
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_bad();
      t_guard();
      t_open();
      stop_test();
   end
   // Watchdog; the scenarios need some 20000 cycles
   initial begin
      #400000;
      mismatches++;
      stop_test();
   end
endmodule : testbench
